// File: src/reset_ctrl_map.svh
`ifndef RESET_CTRL_MAP_SVH
`define RESET_CTRL_MAP_SVH

// ============================================================
// Register offsets
`define RST_ADDR_W 4
`define RST_OFF_STATUS 4'h0
`define RST_OFF_CAUSE 4'h1
`define RST_OFF_STRAPS 4'h2
`define RST_OFF_IRQ_STATUS 4'h3
`define RST_OFF_IRQ_MASK 4'h4
`define RST_OFF_CONTROL 4'h5
`define RST_OFF_CONFIG 4'h6

// ============================================================
// Field positions
`define CAUSE_POR_BIT 0
`define CAUSE_HARD_EXT_BIT 1
`define CAUSE_WDOG_BIT 2
`define CAUSE_BUSMON_BIT 3
`define CAUSE_SOFT_BIT 4
`define CTRL_WDOG_EN_BIT 0
`define CTRL_BUSMON_EN_BIT 1
`define CTRL_SOFT_REQ_BIT 2

// ============================================================
// Reset values
`define RST_CAUSE_RESET 5'h01
`define RST_IRQ_MASK_RESET 5'h00
`define RST_CONTROL_RESET 2'h0
`define RST_CONFIG_RESET 16'h0000

// ============================================================
// Timing, in input clock cycles
`define POR_MIN_CYCLES 16
`define HARD_RELEASE_CYCLES 521
`define HARD_HOLD_CYCLES 521
`define SOFT_HOLD_CYCLES 16
`define SEQ_COUNT_W 10

`endif

// File: src/reset_ctrl_pkg.sv
package reset_ctrl_pkg;

    typedef enum logic [1:0] {
        SEQ_POR = 2'b00,
        SEQ_HARD = 2'b01,
        SEQ_SOFT = 2'b10,
        SEQ_RUN = 2'b11
    } seq_state_t;

    typedef logic [4:0] cause_t;

endpackage : reset_ctrl_pkg

// File: src/reset_controller_sequencer.sv
// Operation
// - Power-on reset resets the PLL, the extended core, peripherals, monitors and clock control, and drives the hard reset pin.
// - Configuration is captured only in the power-on flow and hard or soft resets keep it.
// - The hard reset pin is open drain: pulled low while asserted, never driven high.
// - An external low on the hard reset pin starts the hard flow, driving the pin and resetting the core.
// - A zero watchdog count with the watchdog event enabled starts an internal hard reset.
// - A zero bus monitor count with the bus monitor event enabled starts an internal hard reset.
// - A test port EXTEST, CLAMP or HIGHZ command starts a soft reset that does not touch the pin.
// - The PLL is reset only by power-on reset; clock synthesis state is reset by every reset type.
// - Every reset type resets the monitors, stop and halt logic, the extended core and peripherals.
// - Five strap levels are sampled when power-on reset is released.
// - The reset configuration is written by the host port or loaded over I2C.
// - The hard reset pin is released 521 input clock cycles after power-on reset is released.
// - A readable status record shows the sources of the most recent reset.
`timescale 1ns/100ps
`default_nettype none
`include "reset_ctrl_map.svh"

module reset_controller_sequencer (
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic power_on_reset_n_in,
    input wire logic hard_reset_n_in,
    output logic hard_reset_n_out,
    output logic hard_reset_n_oe_n_out,
    input wire logic [1:0] boot_mode_select_in,
    input wire logic watchdog_enable_strap_in,
    input wire logic host_narrow_bus_strap_in,
    input wire logic host_dsp_strap_in,
    input wire logic watchdog_zero_in,
    input wire logic bus_monitor_zero_in,
    input wire logic tap_soft_reset_in,
    input wire logic config_write_in,
    input wire logic [15:0] config_data_in,
    input wire logic [3:0] reg_addr_in,
    input wire logic [15:0] reg_wdata_in,
    input wire logic reg_write_in,
    input wire logic reg_read_in,
    output logic [15:0] reg_rdata_out,
    output logic irq_out,
    output logic pll_reset_out,
    output logic core_reset_out,
    output logic periph_reset_out,
    output logic monitor_reset_out,
    output logic clock_ctrl_reset_out,
    output logic watchdog_reset_out,
    output logic bus_monitor_reset_out,
    output logic [1:0] boot_mode_select_out,
    output logic watchdog_enable_strap_out,
    output logic host_narrow_bus_strap_out,
    output logic host_dsp_strap_out,
    output logic [15:0] reset_config_out
);

    // ============================================================
    // Decode helpers
    // Hard causes beat a soft request
    function automatic logic hard_pending(input reset_ctrl_pkg::cause_t ev);
        return ev[`CAUSE_BUSMON_BIT:`CAUSE_HARD_EXT_BIT] != 3'h0;
    endfunction : hard_pending

    function automatic logic reg_wr_hit(input logic wr, input logic [3:0] addr, input logic [3:0] off);
        return wr && (addr == off);
    endfunction : reg_wr_hit

    // ============================================================
    // Input synchronisers
    logic por_meta_q;
    logic por_sync_q;
    logic hrst_meta_q;
    logic hrst_sync_q;
    logic [4:0] strap_meta_q;
    logic [4:0] strap_sync_q;

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            por_meta_q <= 1'b0;
            por_sync_q <= 1'b0;
            hrst_meta_q <= 1'b1;
            hrst_sync_q <= 1'b1;
            strap_meta_q <= 5'h00;
            strap_sync_q <= 5'h00;
        end else begin
            por_meta_q <= power_on_reset_n_in;
            por_sync_q <= por_meta_q;
            hrst_meta_q <= hard_reset_n_in;
            hrst_sync_q <= hrst_meta_q;
            strap_meta_q <= {boot_mode_select_in, watchdog_enable_strap_in,
                host_narrow_bus_strap_in, host_dsp_strap_in};
            strap_sync_q <= strap_meta_q;
        end
    end

    // ============================================================
    // Control register and events
    logic [1:0] control_q;
    logic soft_req_q;
    logic wdog_evt;
    logic busmon_evt;
    logic soft_evt;
    logic hard_ext_evt;
    logic pin_drive_q;
    logic [2:0] drive_hist_q;

    assign wdog_evt = watchdog_zero_in & control_q[`CTRL_WDOG_EN_BIT];
    assign busmon_evt = bus_monitor_zero_in & control_q[`CTRL_BUSMON_EN_BIT];
    assign soft_evt = tap_soft_reset_in | soft_req_q;
    // External pin low, own drive excluded
    // Readback lags a release by the synchroniser depth
    assign hard_ext_evt = ~hrst_sync_q & ~pin_drive_q & (drive_hist_q == 3'h0);

    // ============================================================
    // Readback mask
    // Without it our own release reads as an external low
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            drive_hist_q <= 3'h7;
        end else begin
            drive_hist_q <= {drive_hist_q[1:0], pin_drive_q};
        end
    end

    // ============================================================
    // Sequencer
    reset_ctrl_pkg::seq_state_t state_q;
    logic [`SEQ_COUNT_W-1:0] count_q;
    reset_ctrl_pkg::cause_t cause_q;
    reset_ctrl_pkg::cause_t pending;
    logic por_prev_q;
    logic por_release;

    assign por_release = por_sync_q & ~por_prev_q;
    assign pending = {soft_evt, busmon_evt, wdog_evt, hard_ext_evt, 1'b0};

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            por_prev_q <= 1'b0;
        end else begin
            por_prev_q <= por_sync_q;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (rst_in || !por_sync_q) begin
            state_q <= reset_ctrl_pkg::SEQ_POR;
            count_q <= '0;
            cause_q <= `RST_CAUSE_RESET;
        end else begin
            unique case (state_q)
                reset_ctrl_pkg::SEQ_POR: begin
                    if (count_q == `SEQ_COUNT_W'(`HARD_RELEASE_CYCLES - 1)) begin
                        state_q <= reset_ctrl_pkg::SEQ_RUN;
                        count_q <= '0;
                    end else begin
                        count_q <= count_q + `SEQ_COUNT_W'(1);
                    end
                end
                reset_ctrl_pkg::SEQ_HARD: begin
                    // Held for the hold count only; our own drive stands in for the pin reading high
                    if (count_q == `SEQ_COUNT_W'(`HARD_HOLD_CYCLES - 1)) begin
                        if (hrst_sync_q || pin_drive_q) begin
                            state_q <= reset_ctrl_pkg::SEQ_RUN;
                            count_q <= '0;
                        end
                    end else begin
                        count_q <= count_q + `SEQ_COUNT_W'(1);
                    end
                    if (hard_ext_evt) begin
                        count_q <= '0;
                    end
                end
                reset_ctrl_pkg::SEQ_SOFT: begin
                    if (hard_pending(pending)) begin
                        state_q <= reset_ctrl_pkg::SEQ_HARD;
                        count_q <= '0;
                        cause_q <= pending;
                    end else if (count_q == `SEQ_COUNT_W'(`SOFT_HOLD_CYCLES - 1)) begin
                        state_q <= reset_ctrl_pkg::SEQ_RUN;
                        count_q <= '0;
                    end else begin
                        count_q <= count_q + `SEQ_COUNT_W'(1);
                    end
                end
                reset_ctrl_pkg::SEQ_RUN: begin
                    if (hard_pending(pending)) begin
                        state_q <= reset_ctrl_pkg::SEQ_HARD;
                        cause_q <= pending;
                    end else if (pending[4]) begin
                        state_q <= reset_ctrl_pkg::SEQ_SOFT;
                        cause_q <= pending;
                    end
                    count_q <= '0;
                end
            endcase
        end
    end

    // ============================================================
    // Pin and reset outputs
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            pin_drive_q <= 1'b1;
        end else begin
            // Soft reset leaves the pin alone
            pin_drive_q <= (state_q == reset_ctrl_pkg::SEQ_POR) || (state_q == reset_ctrl_pkg::SEQ_HARD);
        end
    end

    assign hard_reset_n_out = 1'b0;
    assign hard_reset_n_oe_n_out = ~pin_drive_q;

    assign pll_reset_out = (state_q == reset_ctrl_pkg::SEQ_POR);
    // All flows reset core and peripherals
    assign core_reset_out = (state_q != reset_ctrl_pkg::SEQ_RUN);
    assign periph_reset_out = core_reset_out;
    assign monitor_reset_out = core_reset_out;
    assign clock_ctrl_reset_out = core_reset_out;
    assign watchdog_reset_out = cause_q[`CAUSE_WDOG_BIT] & core_reset_out;
    assign bus_monitor_reset_out = cause_q[`CAUSE_BUSMON_BIT] & core_reset_out;

    // ============================================================
    // Straps and configuration
    logic [4:0] strap_q;
    logic [15:0] config_q;

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            strap_q <= 5'h00;
        end else if (por_release) begin
            strap_q <= strap_sync_q;
        end
    end

    assign boot_mode_select_out = strap_q[4:3];
    assign watchdog_enable_strap_out = strap_q[2];
    assign host_narrow_bus_strap_out = strap_q[1];
    assign host_dsp_strap_out = strap_q[0];

    // Host or I2C loader writes config
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            config_q <= `RST_CONFIG_RESET;
        end else if (state_q == reset_ctrl_pkg::SEQ_POR && config_write_in) begin
            // Config kept over hard and soft
            config_q <= config_data_in;
        end
    end

    assign reset_config_out = config_q;

    // ============================================================
    // Register port and interrupt
    reset_ctrl_pkg::cause_t irq_status_q;
    reset_ctrl_pkg::cause_t irq_mask_q;
    logic [15:0] rdata_q;
    logic [15:0] rdata_d;
    logic reset_entry;
    reset_ctrl_pkg::cause_t irq_clear;
    reset_ctrl_pkg::cause_t irq_set;

    // One event per flow entry out of normal running
    assign reset_entry = (state_q == reset_ctrl_pkg::SEQ_RUN) && (pending != 5'h00);

    always_ff @(posedge mclk_in) begin
        if (rst_in || !por_sync_q) begin
            control_q <= `RST_CONTROL_RESET;
            irq_mask_q <= `RST_IRQ_MASK_RESET;
            soft_req_q <= 1'b0;
        end else begin
            // Watchdog enable is loaded from its strap at power-on release; software writes override it
            if (por_release) begin
                control_q[`CTRL_WDOG_EN_BIT] <= strap_sync_q[2];
            end
            soft_req_q <= 1'b0;
            if (reg_wr_hit(reg_write_in, reg_addr_in, `RST_OFF_CONTROL)) begin
                control_q <= reg_wdata_in[1:0];
                soft_req_q <= reg_wdata_in[`CTRL_SOFT_REQ_BIT];
            end
            if (reg_wr_hit(reg_write_in, reg_addr_in, `RST_OFF_IRQ_MASK)) begin
                irq_mask_q <= reg_wdata_in[4:0];
            end
        end
    end

    assign irq_clear = reg_wr_hit(reg_write_in, reg_addr_in, `RST_OFF_IRQ_STATUS) ? reg_wdata_in[4:0] : 5'h00;
    assign irq_set = (reset_entry ? pending : 5'h00) | (por_release ? 5'h01 : 5'h00);

    // Set wins over a simultaneous write-one clear
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            irq_status_q <= 5'h00;
        end else begin
            irq_status_q <= (irq_status_q & ~irq_clear) | irq_set;
        end
    end

    assign irq_out = |(irq_status_q & irq_mask_q);

    // Unmapped offsets and idle cycles read as zero
    always_comb begin
        rdata_d = 16'h0000;
        if (reg_read_in) begin
            unique case (reg_addr_in)
                `RST_OFF_STATUS: rdata_d = {14'h0000, state_q};
                `RST_OFF_CAUSE: rdata_d = {11'h000, cause_q};
                `RST_OFF_STRAPS: rdata_d = {11'h000, strap_q};
                `RST_OFF_IRQ_STATUS: rdata_d = {11'h000, irq_status_q};
                `RST_OFF_IRQ_MASK: rdata_d = {11'h000, irq_mask_q};
                `RST_OFF_CONTROL: rdata_d = {14'h0000, control_q};
                `RST_OFF_CONFIG: rdata_d = config_q;
                default: rdata_d = 16'h0000;
            endcase
        end
    end

    // Registered: data stands only in the cycle after the strobe
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            rdata_q <= 16'h0000;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata_out = rdata_q;

endmodule : reset_controller_sequencer
`default_nettype wire

// File: tb/reset_ctrl_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module reset_ctrl_monitor (
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic power_on_reset_n_in,
    input wire logic hard_reset_n_in,
    input wire logic watchdog_zero_in,
    input wire logic bus_monitor_zero_in,
    input wire logic tap_soft_reset_in,
    input wire logic reg_read_in,
    input wire logic hard_reset_n_out,
    input wire logic hard_reset_n_oe_n_out,
    input wire logic [15:0] reg_rdata_out,
    input wire logic irq_out,
    input wire logic pll_reset_out,
    input wire logic core_reset_out,
    input wire logic periph_reset_out,
    input wire logic monitor_reset_out,
    input wire logic clock_ctrl_reset_out,
    input wire logic watchdog_reset_out,
    input wire logic bus_monitor_reset_out,
    input wire logic [1:0] boot_mode_select_out
);
    // ============================================================
    // Cycles since power-on release, saturating
    logic [10:0] por_hi_q;
    always_ff @(posedge mclk_in) begin
        if (!power_on_reset_n_in) por_hi_q <= 11'h000;
        else if (por_hi_q != 11'h7ff) por_hi_q <= por_hi_q + 11'h001;
    end
    default clocking @(posedge mclk_in); endclocking
    default disable iff (rst_in);
    // ============================================================
    // Assertions
    AST_PIN_NEVER_HIGH: assert property (hard_reset_n_out == 1'b0) else $error("pin value driven high");
    AST_POR_ACTIONS: assert property (!power_on_reset_n_in [*6] |->
        !hard_reset_n_oe_n_out && pll_reset_out && core_reset_out) else $error("power-on actions missing");
    AST_RELEASE_DELAY: assert property ($rose(hard_reset_n_oe_n_out) && por_hi_q < 11'd1000 |->
        por_hi_q >= 11'd521 && por_hi_q <= 11'd527) else $error("pin release delay wrong");
    AST_PLL_POR_ONLY: assert property (por_hi_q > 11'd4 |-> !$rose(pll_reset_out)) else $error("pll reset outside por");
    AST_WDOG_FLOW: assert property ($rose(watchdog_reset_out) |->
        $past(watchdog_zero_in) ##[0:2] (!hard_reset_n_oe_n_out && core_reset_out)) else $error("watchdog flow wrong");
    AST_BUSMON_FLOW: assert property ($rose(bus_monitor_reset_out) |->
        $past(bus_monitor_zero_in) ##[0:2] (!hard_reset_n_oe_n_out && core_reset_out)) else $error("busmon flow wrong");
    AST_SOFT_NO_PIN: assert property ($rose(core_reset_out) && ($past(tap_soft_reset_in) ||
        $past(tap_soft_reset_in, 2)) |-> hard_reset_n_oe_n_out [*8]) else $error("soft flow drove pin");
    AST_ALL_BLOCKS: assert property (core_reset_out |->
        periph_reset_out && monitor_reset_out && clock_ctrl_reset_out) else $error("reset set incomplete");
    AST_EXT_PIN: assert property (!hard_reset_n_in [*6] |-> !hard_reset_n_oe_n_out) else $error("pin low not followed");
    AST_STRAPS_HELD: assert property (por_hi_q > 11'd8 |-> $stable(boot_mode_select_out)) else $error("straps changed");
    AST_RDATA_IDLE: assert property (!$past(reg_read_in) |-> reg_rdata_out == 16'h0000) else $error("rdata not idle");
    cover property ($rose(watchdog_reset_out));
    cover property ($rose(bus_monitor_reset_out));
    cover property ($rose(irq_out));
endmodule : reset_ctrl_monitor
bind reset_controller_sequencer reset_ctrl_monitor u_mon (.*);
`default_nettype wire

// File: tb/board_supervisor.sv
`timescale 1ns/100ps
`default_nettype none
module board_supervisor (
    input wire logic mclk_in,
    input wire logic por_req_in,
    input wire logic pin_pull_in,
    input wire logic oe_n_in,
    output logic por_n_out,
    output logic pin_out
);
    int hold_q;
    always_ff @(posedge mclk_in) begin
        if (por_req_in) hold_q <= 20;
        else if (hold_q > 0) hold_q <= hold_q - 1;
    end
    assign por_n_out = (hold_q == 0) && !por_req_in;
    assign pin_out = oe_n_in && !pin_pull_in;
endmodule : board_supervisor
`default_nettype wire

// File: tb/reset_controller_sequencer_tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "reset_ctrl_map.svh"
module reset_controller_sequencer_tb;
    logic mclk_in, rst_in, power_on_reset_n_in, hard_reset_n_in, hard_reset_n_out, hard_reset_n_oe_n_out;
    logic [1:0] boot_mode_select_in, boot_mode_select_out;
    logic watchdog_enable_strap_in, host_narrow_bus_strap_in, host_dsp_strap_in, watchdog_zero_in;
    logic bus_monitor_zero_in, tap_soft_reset_in, config_write_in, reg_write_in, reg_read_in, irq_out;
    logic [15:0] config_data_in, reg_wdata_in, reg_rdata_out, reset_config_out, cfg, rv;
    logic [3:0] reg_addr_in;
    logic pll_reset_out, core_reset_out, periph_reset_out, monitor_reset_out, clock_ctrl_reset_out;
    logic watchdog_reset_out, bus_monitor_reset_out, watchdog_enable_strap_out, host_narrow_bus_strap_out;
    logic host_dsp_strap_out, por_req, pin_pull;
    logic [4:0] straps;
    int n_errors, n_checks, n;
    int bits[4] = '{2, 3, 4, 1};
    reset_controller_sequencer dut (.*);
    board_supervisor sup (.mclk_in(mclk_in), .por_req_in(por_req), .pin_pull_in(pin_pull),
        .oe_n_in(hard_reset_n_oe_n_out), .por_n_out(power_on_reset_n_in), .pin_out(hard_reset_n_in));
    initial begin
        mclk_in = 1'b0;
        forever #50 mclk_in = ~mclk_in;
    end
    // ============================================================
    // Tasks
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge mclk_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_write_in <= 1'b1;
        @(posedge mclk_in);
        reg_write_in <= 1'b0;
    endtask : wr
    // Data stands only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge mclk_in);
        reg_addr_in <= a;
        reg_read_in <= 1'b1;
        @(posedge mclk_in);
        reg_read_in <= 1'b0;
        #1 d = reg_rdata_out;
    endtask : rd
    task automatic finish_test();
        if (n_errors == 0 && n_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : finish_test
    // Sized from one por flow plus five event flows
    initial begin
        #(100 * 6000);
        n_errors++;
        finish_test();
    end
    // ============================================================
    // Main sequence
    initial begin
        void'($urandom(22549));
        straps = 5'($urandom);
        cfg = 16'($urandom);
        {boot_mode_select_in, watchdog_enable_strap_in, host_narrow_bus_strap_in, host_dsp_strap_in} = straps;
        {rst_in, por_req, pin_pull, watchdog_zero_in, bus_monitor_zero_in, tap_soft_reset_in} = 6'b110000;
        {config_write_in, reg_write_in, reg_read_in, reg_addr_in, reg_wdata_in, config_data_in} = '0;
        repeat (12) @(posedge mclk_in);
        rst_in <= 1'b0;
        por_req <= 1'b0;
        wait (power_on_reset_n_in === 1'b1);
        n = 0;
        while (hard_reset_n_oe_n_out !== 1'b1 && n < 700) begin
            @(posedge mclk_in);
            n++;
            config_write_in <= (n == 10);
            config_data_in <= cfg;
        end
        chk("release", 16'(n >= `HARD_RELEASE_CYCLES && n <= `HARD_RELEASE_CYCLES + 6), 16'h0001);
        chk("straps", {11'h000, boot_mode_select_out, watchdog_enable_strap_out, host_narrow_bus_strap_out, host_dsp_strap_out}, {11'h000, straps});
        chk("config", reset_config_out, cfg);
        rd(`RST_OFF_CAUSE, rv);
        chk("cause", rv, 16'h0001);
        wr(`RST_OFF_CONTROL, 16'h0003);
        wr(`RST_OFF_IRQ_STATUS, 16'h001f);
        for (int k = 0; k < 4; k++) begin
            wr(`RST_OFF_IRQ_MASK, (k == 1) ? 16'h0000 : 16'h001f);
            @(posedge mclk_in);
            {tap_soft_reset_in, bus_monitor_zero_in, watchdog_zero_in} <= (k < 3) ? 3'(1 << k) : 3'b000;
            pin_pull <= (k == 3);
            config_write_in <= 1'b1;
            config_data_in <= ~cfg;
            @(posedge mclk_in);
            {tap_soft_reset_in, bus_monitor_zero_in, watchdog_zero_in, config_write_in} <= 4'h0;
            repeat (6) @(posedge mclk_in);
            pin_pull <= 1'b0;
            #1;
            chk("pin_oe", 16'(hard_reset_n_oe_n_out), 16'(k == 2));
            chk("core", 16'(core_reset_out), 16'h0001);
            chk("pll", 16'(pll_reset_out), 16'h0000);
            n = 0;
            while (core_reset_out !== 1'b0 && n < 1200) begin
                @(posedge mclk_in);
                n++;
            end
            chk("hold", 16'((k == 2) ? n < `SOFT_HOLD_CYCLES : n >= `HARD_HOLD_CYCLES - 8), 16'h0001);
            rd(`RST_OFF_CAUSE, rv);
            chk("cause", rv, 16'(1 << bits[k]));
            rd(`RST_OFF_IRQ_STATUS, rv);
            chk("irq_status", rv, 16'(1 << bits[k]));
            chk("irq", 16'(irq_out), 16'(k != 1));
            wr(`RST_OFF_IRQ_STATUS, 16'h001f);
            #1 chk("irq_clr", 16'(irq_out), 16'h0000);
            chk("config_kept", reset_config_out, cfg);
        end
        wr(`RST_OFF_CONTROL, 16'h0007);
        repeat (2) @(posedge mclk_in);
        #1 chk("soft_reg", 16'(core_reset_out), 16'h0001);
        chk("soft_reg_pin", 16'(hard_reset_n_oe_n_out), 16'h0001);
        repeat (20) @(posedge mclk_in);
        rd(`RST_OFF_CAUSE, rv);
        chk("soft_cause", rv, 16'h0010);
        rd(`RST_OFF_STATUS, rv);
        chk("state", rv, 16'h0003);
        rd(`RST_OFF_STRAPS, rv);
        chk("straps_reg", rv, {11'h000, straps});
        rd(`RST_OFF_CONFIG, rv);
        chk("config_reg", rv, cfg);
        rd(4'hf, rv);
        chk("unmapped", rv, 16'h0000);
        finish_test();
    end
endmodule : reset_controller_sequencer_tb
`default_nettype wire
